// >>> logic/dark_level_calibration.v
`include "dark_cal_consts.vh"
`default_nettype none
module dark_level_calibration #(
  parameter PIX_W      = 10,
  parameter COLS       = 64,
  parameter COL_W      = 6,
  parameter PATHS      = 64,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  wire             frame_start,
  input  wire             rolling_shutter,
  input  wire [7:0]       line_kernels,
  input  wire             reg_wr_en,
  input  wire             reg_rd_en,
  input  wire [8:0]       reg_addr,
  input  wire [15:0]      reg_wdata,
  output reg  [15:0]      reg_rdata,
  input  wire             in_valid,
  input  wire [PIX_W-1:0] in_data,
  output reg              in_ready,
  output reg              dark_rows_active,
  output wire             out_valid,
  output wire [PIX_W-1:0] out_data,
  output wire             out_dark,
  input  wire             out_ready
);
  localparam ST_DARK  = 2'b01;
  localparam ST_IMAGE = 2'b10;
  localparam ACC_W    = PIX_W + 7;

  reg  [15:0]        filter_cfg_reg;
  reg  [15:0]        offset_ctl_reg;
  reg  [15:0]        row_cfg_reg;
  reg  [PATHS-1:0]   dark_sample_shortfall_reg;

  reg  [1:0]         state_reg;
  reg  [COL_W-1:0]   col_reg;
  reg  [7:0]         kern_reg;
  reg  [7:0]         row_reg;
  reg  [7:0]         rows_reg;
  reg  [7:0]         row_len_reg;
  reg  [15:0]        kidx_reg;
  reg  [15:0]        avail_reg;
  reg  [2:0]         depth_reg;
  reg                skip_reg;

  reg  [ACC_W-1:0]   acc_mem [0:COLS-1];
  reg  [PIX_W-1:0]   offset_mem [0:COLS-1];

  reg                s1_valid_reg;
  reg  [PIX_W-1:0]   s1_data_reg;
  reg                s1_dark_reg;

  wire [FIFO_AW:0]   fifo_level;
  wire               fifo_wr_ready;

  wire [2:0]   depth_cfg   = filter_cfg_reg[`FILT_DEPTH_MSB:`FILT_DEPTH_LSB];
  wire         auto_en     = offset_ctl_reg[`AUTO_EN_BIT];
  wire [8:0]   manual_mag  = offset_ctl_reg[`OFFSET_MSB:`OFFSET_LSB];
  wire         manual_sub  = offset_ctl_reg[`OFFSET_SIGN_BIT];
  wire         frozen      = auto_en && (manual_mag == `FREEZE_CODE);
  wire [7:0]   rows_cfg    = row_cfg_reg[`ROW_COUNT_MSB:`ROW_COUNT_LSB];
  wire         skip_cfg    = row_cfg_reg[`SKIP_FIRST_BIT];

  // A zero count or length would wrap the end check round to 256 rows or kernels
  function [7:0] at_least_one;
    input [7:0] v;
    begin
      if (v == 8'h00) begin
        at_least_one = 8'h01;
      end else begin
        at_least_one = v;
      end
    end
  endfunction

  // Frame-start geometry
  wire [7:0]   rows_start  = at_least_one(rows_cfg);
  wire [7:0]   len_start   = rolling_shutter ? line_kernels : `GS_ROW_KERNELS;
  wire [7:0]   used_start  = (skip_cfg ? (rows_start - 8'h01) : rows_start);
  wire [15:0]  kern_total  = used_start * len_start;
  wire [15:0]  avail_start = {1'b0, kern_total[15:1]};
  wire [15:0]  need_start  = 16'h0001 << depth_cfg;

  // Every data path reports the same condition
  wire [PATHS-1:0] shortfall_start;
  genvar           p;
  generate
    for (p = 0; p < PATHS; p = p + 1) begin : g_path
      assign shortfall_start[p] = (need_start > avail_start);
    end
  endgenerate

  // Per-sample decode
  wire         accept      = in_valid && in_ready;
  wire         in_dark     = (state_reg == ST_DARK);
  wire         blank_row   = in_dark && skip_reg && (row_reg == 8'h00);
  wire [15:0]  need        = 16'h0001 << depth_reg;
  wire         use_sample  = in_dark && !blank_row && (kidx_reg < need) &&
                             (kidx_reg < avail_reg);
  wire [ACC_W-1:0] acc_sum = ((kidx_reg == 16'h0000) ? {ACC_W{1'b0}} : acc_mem[col_reg]) +
                             {{(ACC_W-PIX_W){1'b0}}, in_data};
  wire [ACC_W-1:0] mean    = acc_sum >> depth_reg;
  wire         last_col    = (col_reg == COLS[COL_W-1:0] - 1'b1);
  wire         last_kern   = (kern_reg == row_len_reg - 8'h01);
  wire         last_row    = (row_reg == rows_reg - 8'h01);
  wire         last_sample = (kidx_reg == need - 16'h0001);

  // Bit 11 set means the result went below zero
  function [PIX_W-1:0] sat10;
    input [11:0] v;
    begin
      if (v[11]) begin
        sat10 = {PIX_W{1'b0}};
      end else if (v > `PIX_MAX) begin
        sat10 = {PIX_W{1'b1}};
      end else begin
        sat10 = v[PIX_W-1:0];
      end
    end
  endfunction

  // Correction for one regular pixel
  reg [11:0] corr_wide;
  always @* begin
    corr_wide = 12'h000;
    if (auto_en) begin
      corr_wide = {2'b00, in_data} - {2'b00, offset_mem[col_reg]};
    end else if (manual_sub) begin
      corr_wide = {2'b00, in_data} - {3'b000, manual_mag};
    end else begin
      corr_wide = {2'b00, in_data} + {3'b000, manual_mag};
    end
  end

  // Register port
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_cfg_reg <= `FILTER_CFG_RESET;
      offset_ctl_reg <= `OFFSET_CTL_RESET;
      row_cfg_reg    <= `ROW_CFG_RESET;
      reg_rdata      <= 16'h0000;
    end else if (ce) begin
      if (reg_wr_en) begin
        case (reg_addr)
          `ADDR_FILTER_CFG:      filter_cfg_reg <= reg_wdata;
          `ADDR_DARK_OFFSET_CTL: offset_ctl_reg <= reg_wdata;
          `ADDR_DARK_ROW_CFG:    row_cfg_reg    <= reg_wdata;
          default: begin
          end
        endcase
      end
      if (reg_rd_en) begin
        if (reg_addr >= `ADDR_SHORTFALL0 && reg_addr <= `ADDR_SHORTFALL3) begin
          reg_rdata <= dark_sample_shortfall_reg[16*(reg_addr[1:0])+:16];
        end else begin
          case (reg_addr)
            `ADDR_FILTER_CFG:      reg_rdata <= filter_cfg_reg;
            `ADDR_DARK_OFFSET_CTL: reg_rdata <= offset_ctl_reg;
            `ADDR_DARK_ROW_CFG:    reg_rdata <= row_cfg_reg;
            default:               reg_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end

  // Frame sequencing and dark row counting
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg                 <= ST_IMAGE;
      col_reg                   <= {COL_W{1'b0}};
      kern_reg                  <= 8'h00;
      row_reg                   <= 8'h00;
      rows_reg                  <= 8'h01;
      row_len_reg               <= `GS_ROW_KERNELS;
      kidx_reg                  <= 16'h0000;
      avail_reg                 <= 16'h0000;
      depth_reg                 <= 3'h0;
      skip_reg                  <= 1'b0;
      dark_rows_active          <= 1'b0;
      dark_sample_shortfall_reg <= {PATHS{1'b0}};
    end else if (ce) begin
      if (frame_start) begin
        state_reg                 <= ST_DARK;
        dark_rows_active          <= 1'b1;
        col_reg                   <= {COL_W{1'b0}};
        kern_reg                  <= 8'h00;
        row_reg                   <= 8'h00;
        rows_reg                  <= rows_start;
        row_len_reg               <= at_least_one(len_start);
        kidx_reg                  <= 16'h0000;
        avail_reg                 <= avail_start;
        depth_reg                 <= depth_cfg;
        skip_reg                  <= skip_cfg;
        dark_sample_shortfall_reg <= shortfall_start;
      end else if (accept) begin
        col_reg <= col_reg + 1'b1;
        case (state_reg)
          ST_DARK: begin
            if (last_col) begin
              if (!blank_row) begin
                kidx_reg <= kidx_reg + 16'h0001;
              end
              if (last_kern) begin
                kern_reg <= 8'h00;
                row_reg  <= row_reg + 8'h01;
                if (last_row) begin
                  state_reg        <= ST_IMAGE;
                  dark_rows_active <= 1'b0;
                end
              end else begin
                kern_reg <= kern_reg + 8'h01;
              end
            end
          end
          ST_IMAGE: begin
          end
          default: begin
            state_reg        <= ST_IMAGE;
            dark_rows_active <= 1'b0;
          end
        endcase
      end
    end
  end

  // Per-column filter and offset store
  integer i;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < COLS; i = i + 1) begin
        acc_mem[i]    <= {ACC_W{1'b0}};
        offset_mem[i] <= {PIX_W{1'b0}};
      end
    end else if (ce && accept && use_sample && auto_en) begin
      acc_mem[col_reg] <= acc_sum;
      if (last_sample && !frozen) begin
        offset_mem[col_reg] <= mean[PIX_W-1:0];
      end
    end
  end

  // Pipeline stage and back-pressure
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_valid_reg <= 1'b0;
      s1_data_reg  <= {PIX_W{1'b0}};
      s1_dark_reg  <= 1'b0;
      in_ready     <= 1'b0;
    end else if (ce) begin
      s1_valid_reg <= accept && !blank_row;
      s1_dark_reg  <= in_dark;
      s1_data_reg  <= in_dark ? in_data : sat10(corr_wide);
      // Three words of margin cover the registered ready and the pipeline stage
      in_ready     <= fifo_wr_ready && (fifo_level < FIFO_DEPTH - 3);
    end
  end

  stream_fifo #(
    .W     (PIX_W + 1),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .wr_valid (s1_valid_reg),
    .wr_data  ({s1_dark_reg, s1_data_reg}),
    .wr_ready (fifo_wr_ready),
    .rd_valid (out_valid),
    .rd_data  ({out_dark, out_data}),
    .rd_ready (out_ready),
    .level    (fifo_level)
  );
endmodule // dark_level_calibration
`default_nettype wire

// >>> include/dark_cal_consts.vh
`ifndef DARK_CAL_CONSTS_VH
`define DARK_CAL_CONSTS_VH

// Register addresses
`define ADDR_FILTER_CFG      9'h080
`define ADDR_DARK_OFFSET_CTL 9'h081
`define ADDR_SHORTFALL0      9'h088
`define ADDR_SHORTFALL3      9'h08B
`define ADDR_DARK_ROW_CFG    9'h0C5

// Field positions
`define AUTO_EN_BIT          0
`define OFFSET_LSB           1
`define OFFSET_MSB           9
`define OFFSET_SIGN_BIT      10
`define ROW_COUNT_LSB        0
`define ROW_COUNT_MSB        7
`define SKIP_FIRST_BIT       8
`define FILT_DEPTH_LSB       8
`define FILT_DEPTH_MSB       10

// Reset values
`define FILTER_CFG_RESET     16'h0000
`define OFFSET_CTL_RESET     16'h0001
`define ROW_CFG_RESET        16'h0102

// Fixed geometry and codes
`define GS_ROW_KERNELS       8'h50
`define FREEZE_CODE          9'h1FF
`define PIX_MAX              12'h3FF

`endif

// >>> logic/stream_fifo.v
`default_nettype none
module stream_fifo #(
  parameter W     = 11,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          ce,
  input  wire          wr_valid,
  input  wire [W-1:0]  wr_data,
  output wire          wr_ready,
  output reg           rd_valid,
  output reg  [W-1:0]  rd_data,
  input  wire          rd_ready,
  output wire [AW:0]   level
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0]   count;
  wire         do_wr;
  wire         do_load;

  assign level    = count + {{AW{1'b0}}, rd_valid};
  assign wr_ready = (count != DEPTH[AW:0]);
  assign do_wr    = wr_valid && wr_ready;
  // Refill the output register when it is empty or being drained
  assign do_load  = (count != {(AW+1){1'b0}}) && (!rd_valid || rd_ready);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      rd_valid <= 1'b0;
      rd_data  <= {W{1'b0}};
    end else if (ce) begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_load) begin
        rd_ptr   <= rd_ptr + 1'b1;
        rd_data  <= mem[rd_ptr];
        rd_valid <= 1'b1;
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_load};
    end
  end

  always @(posedge clk) begin
    if (ce && do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end
endmodule // stream_fifo
`default_nettype wire

// >>> tb/image_receiver_model.sv
`default_nettype none
module image_receiver_model (
  input  wire logic clk,
  input  wire logic stall,
  output var  logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  initial out_ready = 1'b0;
  // Slow receiver: refuses one cycle in four, and all while stalled
  always @(negedge clk) begin
    ph <= ph + 2'h1;
    out_ready <= !stall && ph != 2'h3;
  end
endmodule // image_receiver_model
`default_nettype wire

// >>> tb/dark_level_calibration_props.sv
`include "dark_cal_consts.vh"
`default_nettype none
module dark_level_calibration_props #(
  parameter PIX_W = 10
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             ce,
  input wire logic             frame_start,
  input wire logic             rolling_shutter,
  input wire logic [7:0]       line_kernels,
  input wire logic             reg_wr_en,
  input wire logic             reg_rd_en,
  input wire logic [8:0]       reg_addr,
  input wire logic [15:0]      reg_wdata,
  input wire logic [15:0]      reg_rdata,
  input wire logic             in_valid,
  input wire logic             in_ready,
  input wire logic             dark_rows_active,
  input wire logic             out_valid,
  input wire logic [PIX_W-1:0] out_data,
  input wire logic             out_dark,
  input wire logic             out_ready
);
  logic [15:0] cfg_reg;
  logic [7:0]  rows_reg;
  logic [7:0]  len_reg;
  logic        rs_reg;
  int          cnt_reg;
  // Dark samples taken since the frame began, against the latched geometry
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= `ROW_CFG_RESET;
      rows_reg <= 8'h01;
      len_reg <= 8'h01;
      rs_reg <= 1'b0;
      cnt_reg <= 0;
    end else if (ce) begin
      if (reg_wr_en && reg_addr == `ADDR_DARK_ROW_CFG)
        cfg_reg <= reg_wdata;
      if (frame_start) begin
        cnt_reg <= 0;
        rs_reg <= rolling_shutter;
        rows_reg <= (cfg_reg[7:0] == 8'h00) ? 8'h01 : cfg_reg[7:0];
        len_reg <= !rolling_shutter ? `GS_ROW_KERNELS :
                   (line_kernels == 8'h00 ? 8'h01 : line_kernels);
      end else if (dark_rows_active && in_valid && in_ready)
        cnt_reg <= cnt_reg + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_dark_start: assert property (ce && frame_start |=> dark_rows_active)
    else $error("dark phase did not start");
  a_dark_bound: assert property (dark_rows_active |-> cnt_reg < rows_reg * len_reg * 64)
    else $error("too many dark samples");
  a_gs_len: assert property ($fell(dark_rows_active) && !rs_reg |->
    cnt_reg == rows_reg * 80 * 64) else $error("global dark row length wrong");
  a_rs_len: assert property ($fell(dark_rows_active) && rs_reg |->
    cnt_reg == rows_reg * len_reg * 64) else $error("rolling dark row length wrong");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid &&
    $stable(out_data) && $stable(out_dark)) else $error("output changed while stalled");
  a_reset_quiet: assert property ($fell(rst) |-> !out_valid && !dark_rows_active && !in_ready)
    else $error("outputs busy after reset");
  a_ready_rise: assert property ($fell(rst) && ce |=> in_ready)
    else $error("input not ready after reset");
  a_read_stand: assert property (!(ce && reg_rd_en) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (ce && reg_rd_en && reg_addr == 9'h1FE |=> reg_rdata == 16'h0)
    else $error("unmapped read not zero");
endmodule // dark_level_calibration_props
bind dark_level_calibration dark_level_calibration_props #(.PIX_W(PIX_W)) props_u (
  .clk, .rst, .ce, .frame_start, .rolling_shutter, .line_kernels, .reg_wr_en, .reg_rd_en,
  .reg_addr, .reg_wdata, .reg_rdata, .in_valid, .in_ready, .dark_rows_active, .out_valid,
  .out_data, .out_dark, .out_ready);
`default_nettype wire

// >>> tb/dark_level_calibration_tb.sv
`default_nettype none
module dark_level_calibration_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        fs = 1'b0;
  logic        rs = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        iv = 1'b0;
  logic        stall = 1'b0;
  logic [7:0]  lk = 8'h02;
  logic [8:0]  ad = 9'h000;
  logic [15:0] wd = 16'h0000;
  logic [9:0]  id = 10'h000;
  logic [31:0] s = 32'h3BEA;
  logic [8:0]  mo = 9'h000;
  logic [10:0] q[$];
  int          off[64];
  int          err_count = 0;
  int          total_checks = 0;
  bit          au = 1'b1;
  bit          fz = 1'b0;
  bit          sb = 1'b0;
  wire [15:0]  rdat;
  wire [9:0]   odat;
  wire         ir;
  wire         ov;
  wire         od;
  wire         ordy;
  dark_level_calibration dut_u (
    .clk(clk), .rst(rst), .ce(1'b1), .frame_start(fs), .rolling_shutter(rs),
    .line_kernels(lk), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(ad), .reg_wdata(wd),
    .reg_rdata(rdat), .in_valid(iv), .in_data(id), .in_ready(ir), .dark_rows_active(),
    .out_valid(ov), .out_data(odat), .out_dark(od), .out_ready(ordy));
  image_receiver_model rx_u (.clk(clk), .stall(stall), .out_ready(ordy));
  always #5 clk = ~clk;
  function automatic int rnd();
    s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s[9:0];
  endfunction
  task automatic chk(string n, logic [15:0] v, logic [15:0] e);
    total_checks++;
    if (v !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wreg(logic [8:0] a, logic [15:0] d);
    @(negedge clk);
    ad = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rreg(logic [8:0] a, logic [15:0] e);
    @(negedge clk);
    ad = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk("reg_rdata", rdat, e);
  endtask
  task automatic pix(logic [9:0] d);
    @(negedge clk);
    iv = 1'b1;
    id = d;
    while (ir !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic frame(int rows, bit skp, logic [2:0] dp);
    int d;
    int e;
    int u;
    int b;
    int acc[64];
    bit sf;
    wreg(9'h080, {5'h00, dp, 8'h00});
    wreg(9'h0C5, {7'h00, skp, rows[7:0]});
    u = rs ? lk : 80;
    b = skp ? u : 0;
    sf = (2 ** dp) > ((rows - skp) * u / 2);
    @(negedge clk);
    fs = 1'b1;
    @(negedge clk);
    fs = 1'b0;
    for (int k = 0; k < rows * u * 64; k++) begin
      d = rnd();
      if (!(skp && k < u * 64)) q.push_back({1'b1, d[9:0]});
      if (k / 64 >= b && k / 64 < b + (1 << dp)) acc[k % 64] += d;
      pix(d[9:0]);
    end
    if (au && !fz && !sf)
      for (int c = 0; c < 64; c++) off[c] = acc[c] >> dp;
    for (int k = 0; k < 64; k++) begin
      d = rnd();
      e = au ? d - off[k] : (sb ? d - mo : d + mo);
      e = e < 0 ? 0 : (e > 1023 ? 1023 : e);
      q.push_back({1'b0, e[9:0]});
      pix(d[9:0]);
    end
    @(negedge clk);
    iv = 1'b0;
    for (int i = 0; i < 400 && q.size() > 0; i++) @(negedge clk);
    chk("pending", q.size(), 0);
    chk("out_valid", ov, 0);
    for (int a = 0; a < 4; a++) rreg(9'h088 + 9'(a), {16{sf}});
  endtask
  always @(posedge clk) begin
    if (ov === 1'b1 && ordy === 1'b1) begin
      if (q.size() == 0) chk("extra", 16'h1, 16'h0);
      else chk("pixel", {5'h00, od, odat}, {5'h00, q.pop_front()});
    end
  end
  initial begin
    #300000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rreg(9'h081, 16'h0001);
    rreg(9'h0C5, 16'h0102);
    rreg(9'h080, 16'h0000);
    rreg(9'h1FE, 16'h0000);
    wreg(9'h088, 16'h1234);
    frame(2, 1'b1, 3'h1);
    stall = 1'b1;
    fork
      frame(3, 1'b1, 3'h0);
      begin
        repeat (400) @(negedge clk);
        chk("in_ready", ir, 0);
        stall = 1'b0;
      end
    join
    wreg(9'h081, 16'h03FF);
    fz = 1'b1;
    frame(3, 1'b1, 3'h0);
    wreg(9'h081, 16'h0003);
    fz = 1'b0;
    frame(2, 1'b0, 3'h1);
    au = 1'b0;
    for (int k = 0; k < 2; k++) begin
      sb = k[0];
      mo = 9'(rnd());
      wreg(9'h081, {5'h00, sb, mo, 1'b0});
      frame(1, 1'b0, 3'h0);
    end
    rs = 1'b0;
    frame(1, 1'b0, 3'h0);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rreg(9'h081, 16'h0001);
    test_done();
  end
endmodule // dark_level_calibration_tb
`default_nettype wire
